/* core/irc_carrier_gen.sv */
// Carrier generator: 7-bit half-period counter on a half-rate enable.
// Assumes periods are stable registers driven by the timer top.
`timescale 1ns/1ps
module irc_carrier_gen (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  run,
    input  wire logic                  force_high,
    input  wire irc_pkg::irc_periods_t periods,
    output logic                       carrier,
    output logic                       carrier_fall
);
    irc_pkg::irc_cg_state_t state_reg;
    irc_pkg::irc_cg_state_t state_next;
    logic [6:0]             cnt_reg;
    logic [6:0]             cnt_next;
    logic                   div_reg;
    logic                   div_next;
    logic                   fall_reg;
    logic                   fall_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        fall_next  = 1'b0;
        div_next   = run ? ~div_reg : 1'b0;
        if (!run) begin
            state_next = irc_pkg::CG_IDLE;
            cnt_next   = 7'h00;
        end else if (force_high) begin
            state_next = irc_pkg::CG_HIGH;
            cnt_next   = 7'h00;
        end else begin
            case (state_reg)
                irc_pkg::CG_IDLE: begin
                    // Buffer-loaded start waits one low phase
                    state_next = irc_pkg::CG_LOW;
                    cnt_next   = 7'h00;
                end
                irc_pkg::CG_HIGH: begin
                    if (div_reg) begin
                        if (cnt_reg == periods.high_period) begin
                            state_next = irc_pkg::CG_LOW;
                            cnt_next   = 7'h00;
                            fall_next  = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 7'h01;
                        end
                    end
                end
                irc_pkg::CG_LOW: begin
                    if (div_reg) begin
                        if (cnt_reg == periods.low_period) begin
                            state_next = irc_pkg::CG_HIGH;
                            cnt_next   = 7'h00;
                        end else begin
                            cnt_next = cnt_reg + 7'h01;
                        end
                    end
                end
                default: begin
                    state_next = irc_pkg::CG_IDLE;
                    cnt_next   = 7'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= irc_pkg::CG_IDLE;
            cnt_reg   <= 7'h00;
            div_reg   <= 1'b0;
            fall_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            div_reg   <= div_next;
            fall_reg  <= fall_next;
        end
    end

    assign carrier      = (state_reg == irc_pkg::CG_HIGH);
    assign carrier_fall = fall_reg;

    property p_half_end;
        @(posedge mclk) disable iff (sys_rst)
        (run && !force_high && state_reg == irc_pkg::CG_HIGH && div_reg
            && cnt_reg == periods.high_period)
            |=> (state_reg == irc_pkg::CG_LOW) && carrier_fall;
    endproperty
    a_half_end: assert property (p_half_end)
        else $error("High phase did not end after period plus one");

    property p_halt;
        @(posedge mclk) disable iff (sys_rst)
        !run |=> !carrier ##1 (!carrier || $past(run));
    endproperty
    a_halt: assert property (p_halt)
        else $error("Carrier runs while halted");
endmodule

/* core/irc_timer_top.sv */
// 8-bit match timer with infrared carrier output gating.
// Assumes the CPU drives register file and peripheral ops on mclk.
`timescale 1ns/1ps
module irc_timer_top (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [6:0] rf_addr,
    input  wire logic       rf_wr,
    input  wire logic       rf_rd,
    input  wire logic [3:0] rf_wdata,
    output logic      [3:0] rf_rdata,
    input  wire logic [7:0] per_addr,
    input  wire logic       peripheral_write_op,
    input  wire logic       peripheral_read_op,
    input  wire logic [7:0] transfer_buffer_in,
    output logic      [7:0] transfer_buffer_out,
    output logic            timer_match_flag,
    output logic            rem_out
);
    logic [3:0] ctrl_reg;
    logic [3:0] ctrl_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] limit_reg;
    logic [7:0] limit_next;
    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic [7:0] high_reg;
    logic [7:0] high_next;
    logic [7:0] presc_reg;
    logic [7:0] presc_next;
    logic       flag_reg;
    logic       flag_next;
    logic       gate_reg;
    logic       gate_next;
    logic       gbuf_reg;
    logic       gbuf_next;
    logic       hold_reg;
    logic       hold_next;
    logic       rem_reg;
    logic       rem_next;
    logic       run_reg;
    logic [3:0] rf_rdata_reg;
    logic [3:0] rf_rdata_next;
    logic [7:0] tb_out_reg;
    logic [7:0] tb_out_next;

    logic                  strobe;
    logic                  flag_clr;
    logic                  sw_gate_set;
    logic                  tick;
    logic                  match;
    logic                  run;
    logic                  carrier;
    logic                  carrier_fall;
    logic [7:0]            mask;
    irc_pkg::irc_periods_t periods;

    assign strobe = rf_wr && rf_addr == irc_pkg::RF_TIMER_CTRL
        && rf_wdata[irc_pkg::CTRL_STROBE_BIT];
    assign flag_clr = rf_wr && rf_addr == irc_pkg::RF_MATCH_FLAG
        && !rf_wdata[irc_pkg::FLAG_BIT];
    assign sw_gate_set = rf_wr && rf_addr == irc_pkg::RF_GATE
        && rf_wdata[irc_pkg::GATE_BIT] && !gate_reg;
    assign periods.high_period = high_reg[6:0];
    assign periods.low_period  = low_reg[6:0];
    // Timer clock use keeps the generator alive with the gate closed
    assign run = gate_reg || hold_reg
        || ctrl_reg[1:0] == irc_pkg::SEL_CARRIER;

    irc_carrier_gen u_carrier (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .run          (run),
        .force_high   (sw_gate_set && !run_reg),
        .periods      (periods),
        .carrier      (carrier),
        .carrier_fall (carrier_fall)
    );

    // Count clock selection
    always_comb begin
        presc_next = presc_reg + 8'h01;
        case (ctrl_reg[1:0])
            irc_pkg::SEL_DIV32:  mask = irc_pkg::MASK_DIV32;
            irc_pkg::SEL_DIV64:  mask = irc_pkg::MASK_DIV64;
            irc_pkg::SEL_DIV256: mask = irc_pkg::MASK_DIV256;
            default:             mask = 8'h00;
        endcase
        // Falling edge of a divided clock: masked bits roll over
        if (ctrl_reg[1:0] == irc_pkg::SEL_CARRIER) begin
            tick = carrier_fall;
        end else begin
            tick = (presc_reg & mask) == mask;
        end
    end

    // Timer, flag and control
    always_comb begin
        ctrl_next  = ctrl_reg;
        count_next = count_reg;
        limit_next = limit_reg;
        match      = 1'b0;
        if (rf_wr && rf_addr == irc_pkg::RF_TIMER_CTRL) begin
            ctrl_next = {rf_wdata[3], 1'b0, rf_wdata[1:0]};
        end
        if (peripheral_write_op && per_addr == irc_pkg::PER_TIMER_LIMIT) begin
            limit_next = transfer_buffer_in;
        end
        if (strobe) begin
            count_next = irc_pkg::COUNT_RESET;
        end else if (ctrl_reg[irc_pkg::CTRL_EN_BIT] && tick) begin
            if (count_reg == limit_reg) begin
                count_next = 8'h00;
            end else begin
                count_next = count_reg + 8'h01;
            end
            // A zero limit never raises the flag
            match = count_next == limit_reg
                && limit_reg != 8'h00;
        end
        // Set wins over a software clear in the same cycle
        flag_next = match || (flag_reg && !flag_clr && !strobe);
    end

    // Carrier registers, gate and pin
    always_comb begin
        low_next  = low_reg;
        high_next = high_reg;
        gate_next = gate_reg;
        gbuf_next = gbuf_reg;
        if (peripheral_write_op && per_addr == irc_pkg::PER_CARRIER_LOW) begin
            low_next = transfer_buffer_in;
        end
        if (peripheral_write_op
            && per_addr == irc_pkg::PER_CARRIER_HIGH) begin
            high_next = transfer_buffer_in;
        end
        if (rf_wr && rf_addr == irc_pkg::RF_GATE) begin
            gate_next = rf_wdata[irc_pkg::GATE_BIT];
            gbuf_next = rf_wdata[irc_pkg::GATE_BUF_BIT];
        end
        if (match) begin
            gate_next = gbuf_reg;
        end
        if (hold_reg) begin
            hold_next = !carrier_fall;
        end else begin
            hold_next = match && gate_reg && !gbuf_reg
                && rem_reg && carrier;
        end
        if (hold_next) begin
            rem_next = 1'b1;
        end else if (gate_next) begin
            rem_next = low_reg[irc_pkg::LOW_STEADY_BIT]
                ? 1'b1 : carrier;
        end else begin
            rem_next = 1'b0;
        end
    end

    // Read paths
    always_comb begin
        rf_rdata_next = rf_rdata_reg;
        tb_out_next   = tb_out_reg;
        if (rf_rd) begin
            case (rf_addr)
                irc_pkg::RF_TIMER_CTRL:
                    rf_rdata_next = {ctrl_reg[3], 1'b0, ctrl_reg[1:0]};
                irc_pkg::RF_MATCH_FLAG:
                    rf_rdata_next = {3'h0, flag_reg};
                irc_pkg::RF_GATE:
                    rf_rdata_next = {2'h0, gbuf_reg, gate_reg};
                default:
                    rf_rdata_next = 4'h0;
            endcase
        end
        if (peripheral_read_op) begin
            case (per_addr)
                irc_pkg::PER_CARRIER_LOW:  tb_out_next = low_reg;
                irc_pkg::PER_CARRIER_HIGH: tb_out_next = high_reg;
                irc_pkg::PER_TIMER_COUNT:  tb_out_next = count_reg;
                default:                   tb_out_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_reg     <= irc_pkg::CTRL_RESET;
            count_reg    <= irc_pkg::COUNT_RESET;
            limit_reg    <= irc_pkg::LIMIT_RESET;
            low_reg      <= irc_pkg::PERIOD_RESET;
            high_reg     <= irc_pkg::PERIOD_RESET;
            presc_reg    <= 8'h00;
            flag_reg     <= 1'b0;
            gate_reg     <= 1'b0;
            gbuf_reg     <= 1'b0;
            hold_reg     <= 1'b0;
            rem_reg      <= 1'b0;
            run_reg      <= 1'b0;
            rf_rdata_reg <= 4'h0;
            tb_out_reg   <= 8'h00;
        end else begin
            ctrl_reg     <= ctrl_next;
            count_reg    <= count_next;
            limit_reg    <= limit_next;
            low_reg      <= low_next;
            high_reg     <= high_next;
            presc_reg    <= presc_next;
            flag_reg     <= flag_next;
            gate_reg     <= gate_next;
            gbuf_reg     <= gbuf_next;
            hold_reg     <= hold_next;
            rem_reg      <= rem_next;
            run_reg      <= run;
            rf_rdata_reg <= rf_rdata_next;
            tb_out_reg   <= tb_out_next;
        end
    end

    assign rf_rdata            = rf_rdata_reg;
    assign transfer_buffer_out = tb_out_reg;
    assign timer_match_flag    = flag_reg;
    assign rem_out             = rem_reg;

    sequence s_match;
        match && !strobe;
    endsequence

    property p_match_flag;
        @(posedge mclk) disable iff (sys_rst)
        s_match |=> flag_reg && count_reg == limit_reg;
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("Match did not set the flag");

    property p_zero_limit;
        @(posedge mclk) disable iff (sys_rst)
        $rose(flag_reg) |-> $past(limit_reg) != 8'h00;
    endproperty
    a_zero_limit: assert property (p_zero_limit)
        else $error("Flag raised with zero limit");

    property p_strobe;
        @(posedge mclk) disable iff (sys_rst)
        strobe |=> count_reg == 8'h00 && !flag_reg && !ctrl_reg[2];
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("Reset bit did not clear count and flag");

    property p_stopped;
        @(posedge mclk) disable iff (sys_rst)
        (!ctrl_reg[irc_pkg::CTRL_EN_BIT] && !strobe) |=> $stable(count_reg);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("Counter moved while disabled");

    property p_wrap;
        @(posedge mclk) disable iff (sys_rst)
        (ctrl_reg[irc_pkg::CTRL_EN_BIT] && tick && !strobe
            && count_reg == limit_reg) |=> count_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Counter did not wrap after match");

    property p_gate_load;
        @(posedge mclk) disable iff (sys_rst)
        s_match |=> gate_reg == $past(gbuf_reg);
    endproperty
    a_gate_load: assert property (p_gate_load)
        else $error("Gate not loaded from buffer on match");

    sequence s_hold;
        hold_reg && !carrier_fall;
    endsequence

    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
        s_hold |=> rem_out;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Pin dropped before carrier fell");

    property p_gate_low;
        @(posedge mclk) disable iff (sys_rst)
        (!gate_next && !hold_next) |=> !rem_out;
    endproperty
    a_gate_low: assert property (p_gate_low)
        else $error("Pin not low with gate closed");

    property p_steady;
        @(posedge mclk) disable iff (sys_rst)
        (gate_next && !hold_next && low_reg[7]) |=> rem_out;
    endproperty
    a_steady: assert property (p_steady)
        else $error("Steady high not driven");

    property p_ctrl_read;
        @(posedge mclk) disable iff (sys_rst)
        (rf_rd && rf_addr == irc_pkg::RF_TIMER_CTRL) |=> !rf_rdata[2];
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("Reset bit read back as one");
endmodule

/* inc/irc_pkg.sv */
// Constants, states and types for the timer and carrier generator.
// Assumes a 4-bit register file and an 8-bit peripheral transfer buffer.
package irc_pkg;
    // Peripheral register addresses
    localparam logic [7:0] PER_CARRIER_LOW  = 8'h03;
    localparam logic [7:0] PER_CARRIER_HIGH = 8'h04;
    localparam logic [7:0] PER_TIMER_COUNT  = 8'h05;
    localparam logic [7:0] PER_TIMER_LIMIT  = 8'h06;
    // Register file addresses
    localparam logic [6:0] RF_TIMER_CTRL    = 7'h33;
    localparam logic [6:0] RF_GATE          = 7'h3a;
    localparam logic [6:0] RF_MATCH_FLAG    = 7'h3f;
    // Field positions
    localparam int CTRL_EN_BIT     = 3;
    localparam int CTRL_STROBE_BIT = 2;
    localparam int FLAG_BIT        = 0;
    localparam int GATE_BIT        = 0;
    localparam int GATE_BUF_BIT    = 1;
    localparam int LOW_STEADY_BIT  = 7;
    // Values after reset
    localparam logic [3:0] CTRL_RESET   = 4'h8;
    localparam logic [7:0] LIMIT_RESET  = 8'hff;
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    // Clock select codes
    localparam logic [1:0] SEL_DIV32   = 2'h0;
    localparam logic [1:0] SEL_DIV64   = 2'h1;
    localparam logic [1:0] SEL_DIV256  = 2'h2;
    localparam logic [1:0] SEL_CARRIER = 2'h3;
    // Prescaler masks: tick when the masked bits are all ones
    localparam logic [7:0] MASK_DIV32  = 8'h1f;
    localparam logic [7:0] MASK_DIV64  = 8'h3f;
    localparam logic [7:0] MASK_DIV256 = 8'hff;

    typedef enum logic [1:0] {
        CG_IDLE = 2'h0,
        CG_LOW  = 2'h1,
        CG_HIGH = 2'h3
    } irc_cg_state_t;

    typedef struct packed {
        logic [6:0] high_period;
        logic [6:0] low_period;
    } irc_periods_t;
endpackage

/* tb/ir_carrier_timer_test.sv */
// Self-checking bench for the match timer and carrier output.
// Assumes the design keeps its registers on the CPU side ports only.
`timescale 1ns/1ps
module ir_carrier_timer_test;
    logic        mclk;
    logic        sys_rst;
    logic [6:0]  rf_addr;
    logic        rf_wr;
    logic        rf_rd;
    logic [3:0]  rf_wdata;
    logic [3:0]  rf_rdata;
    logic [7:0]  per_addr;
    logic        per_wr;
    logic        per_rd;
    logic [7:0]  tb_in;
    logic [7:0]  tb_out;
    logic        flag;
    logic        rem_out;
    logic [15:0] high_w;
    logic [15:0] low_w;
    int          error_cnt;
    int          comparisons;
    logic [3:0]  r4;
    logic [7:0]  r8;
    int          n;

    irc_timer_top dut (
        .mclk(mclk), .sys_rst(sys_rst), .rf_addr(rf_addr), .rf_wr(rf_wr),
        .rf_rd(rf_rd), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
        .per_addr(per_addr), .peripheral_write_op(per_wr),
        .peripheral_read_op(per_rd), .transfer_buffer_in(tb_in),
        .transfer_buffer_out(tb_out), .timer_match_flag(flag),
        .rem_out(rem_out)
    );

    irc_led_model led (
        .mclk(mclk), .rem_out(rem_out), .high_w(high_w), .low_w(low_w)
    );

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    task automatic results();
        $display("Checks %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Drive 1 ns after each edge so the design samples stable inputs
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic rf_write(input logic [6:0] a, input logic [3:0] d);
        rf_addr = a; rf_wdata = d; rf_wr = 1'b1;
        tick(1);
        rf_wr = 1'b0;
        // Idle edge so a following write never re-raises in this step
        tick(1);
    endtask

    task automatic rf_read(input logic [6:0] a, output logic [3:0] d);
        rf_addr = a; rf_rd = 1'b1;
        tick(1);
        rf_rd = 1'b0;
        tick(1);
        d = rf_rdata;
    endtask

    task automatic per_write(input logic [7:0] a, input logic [7:0] d);
        per_addr = a; tb_in = d; per_wr = 1'b1;
        tick(1);
        per_wr = 1'b0;
        tick(1);
    endtask

    task automatic per_read(input logic [7:0] a, output logic [7:0] d);
        per_addr = a; per_rd = 1'b1;
        tick(1);
        per_rd = 1'b0;
        tick(1);
        d = tb_out;
    endtask

    // Bounded wait for the match flag; cycles taken come back in k
    task automatic wait_flag(output int k);
        k = 0;
        while (flag !== 1'b1) begin
            tick(1);
            k++;
            if (k > 1000) begin
                error_cnt++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, flag, 1'b1);
                results();
            end
        end
    endtask

    // Counts cycles where the pin differs from a steady level
    task automatic hold_check(input logic lvl, input int k);
        int bad;
        bad = 0;
        repeat (k) begin
            tick(1);
            if (rem_out !== lvl) bad++;
        end
        check8(bad[7:0], 8'h00);
    endtask

    task automatic t_reset_values();
        rf_read(irc_pkg::RF_TIMER_CTRL, r4);
        check8({4'h0, r4}, {4'h0, irc_pkg::CTRL_RESET});
        per_read(irc_pkg::PER_TIMER_LIMIT, r8);
        check8(r8, 8'h00);
        check8({7'h00, rem_out}, 8'h00);
    endtask

    task automatic t_registers();
        per_write(irc_pkg::PER_CARRIER_LOW, 8'h5a);
        per_write(irc_pkg::PER_CARRIER_HIGH, 8'ha5);
        per_read(irc_pkg::PER_CARRIER_LOW, r8);
        check8(r8, 8'h5a);
        per_read(irc_pkg::PER_CARRIER_HIGH, r8);
        check8(r8, 8'ha5);
        rf_write(irc_pkg::RF_TIMER_CTRL, 4'h4);
        per_write(irc_pkg::PER_TIMER_COUNT, 8'h55);
        tick(200);
        per_read(irc_pkg::PER_TIMER_COUNT, r8);
        check8(r8, 8'h00);
        rf_read(irc_pkg::RF_TIMER_CTRL, r4);
        check8({4'h0, r4}, 8'h00);
    endtask

    // Every clock source, with the limit at two ticks
    task automatic t_clock_select();
        int div;
        per_write(irc_pkg::PER_CARRIER_LOW, 8'h00);
        per_write(irc_pkg::PER_CARRIER_HIGH, 8'h00);
        per_write(irc_pkg::PER_TIMER_LIMIT, 8'h02);
        for (int s = 0; s < 4; s++) begin
            div = (s == 0) ? 32 : (s == 1) ? 64 : (s == 2) ? 256 : 4;
            rf_write(irc_pkg::RF_TIMER_CTRL, 4'hc | s[3:0]);
            check8({7'h00, flag}, 8'h00);
            wait_flag(n);
            check8({7'h00, (n >= div && n <= 2 * div + 6)}, 8'h01);
            per_read(irc_pkg::PER_TIMER_COUNT, r8);
            check8({7'h00, r8 <= 8'h02}, 8'h01);
        end
        // Stop first, so no fresh match races the software clear
        rf_write(irc_pkg::RF_TIMER_CTRL, 4'h3);
        rf_read(irc_pkg::RF_MATCH_FLAG, r4);
        check8({4'h0, r4}, 8'h01);
        rf_write(irc_pkg::RF_MATCH_FLAG, 4'h0);
        rf_read(irc_pkg::RF_MATCH_FLAG, r4);
        check8({4'h0, r4}, 8'h00);
    endtask

    task automatic t_carrier();
        rf_write(irc_pkg::RF_TIMER_CTRL, 4'h4);
        per_write(irc_pkg::PER_CARRIER_HIGH, 8'h02);
        per_write(irc_pkg::PER_CARRIER_LOW, 8'h04);
        rf_write(irc_pkg::RF_GATE, 4'h1);
        tick(100);
        check8(high_w[7:0], 8'h06);
        check8(low_w[7:0], 8'h0a);
        per_write(irc_pkg::PER_CARRIER_LOW, 8'h84);
        tick(30);
        hold_check(1'b1, 40);
        per_write(irc_pkg::PER_CARRIER_LOW, 8'h04);
        rf_write(irc_pkg::RF_GATE, 4'h0);
        tick(30);
        hold_check(1'b0, 60);
    endtask

    // Gate follows its buffer on each match
    task automatic t_gate_load();
        per_write(irc_pkg::PER_CARRIER_HIGH, 8'h00);
        per_write(irc_pkg::PER_CARRIER_LOW, 8'h00);
        per_write(irc_pkg::PER_TIMER_LIMIT, 8'h02);
        rf_write(irc_pkg::RF_GATE, 4'h2);
        rf_write(irc_pkg::RF_TIMER_CTRL, 4'hc);
        hold_check(1'b0, 20);
        wait_flag(n);
        tick(40);
        check8(high_w[7:0], 8'h02);
        rf_write(irc_pkg::RF_GATE, 4'h1);
        rf_write(irc_pkg::RF_MATCH_FLAG, 4'h0);
        wait_flag(n);
        tick(20);
        hold_check(1'b0, 100);
    endtask

    // A zero limit must never raise the flag; software is warned off it
    task automatic t_zero_limit();
        per_write(irc_pkg::PER_TIMER_LIMIT, 8'h00);
        rf_write(irc_pkg::RF_TIMER_CTRL, 4'hc);
        tick(600);
        check8({7'h00, flag}, 8'h00);
    endtask

    initial begin
        error_cnt = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        rf_addr = 7'h00; rf_wr = 1'b0; rf_rd = 1'b0; rf_wdata = 4'h0;
        per_addr = 8'h00; per_wr = 1'b0; per_rd = 1'b0; tb_in = 8'h00;
        tick(6);
        sys_rst = 1'b0;
        t_reset_values();
        t_registers();
        t_clock_select();
        t_carrier();
        t_gate_load();
        t_zero_limit();
        results();
    end
endmodule

/* tb/irc_led_model.sv */
// Infrared LED on the carrier pin: measures the last high and low widths.
// Assumes the pin is sampled on every rising mclk edge.
`timescale 1ns/1ps
module irc_led_model (
    input  wire logic        mclk,
    input  wire logic        rem_out,
    output logic      [15:0] high_w,
    output logic      [15:0] low_w
);
    logic        last_lvl;
    logic [15:0] run_len;

    initial begin
        last_lvl = 1'b0;
        run_len  = 16'h0000;
        high_w   = 16'h0000;
        low_w    = 16'h0000;
    end

    // Width of a finished phase only, so a steady pin shows no pulse
    always @(posedge mclk) begin
        if (rem_out !== last_lvl) begin
            if (last_lvl === 1'b1) high_w <= run_len;
            else low_w <= run_len;
            run_len  <= 16'h0001;
            last_lvl <= rem_out;
        end else begin
            run_len <= run_len + 16'h0001;
        end
    end
endmodule
